// File: pkg/rfhsc_pkg.sv
package rfhsc_pkg;
    // clock and pin timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_CK_NS       = 500;
    localparam int T_SU_NS       = 60;
    localparam int T_GAP_NS      = 5000;
    localparam int CK_HALF_CYC   = (T_CK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SU_CYC        = (T_SU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC       = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // serial access shape
    localparam int SER_W    = 12;
    localparam int CFG_BITS = 12;
    localparam int SYM_BITS = 3;
    localparam logic [3:0] CFG_NBITS = 4'hC;
    localparam logic [3:0] SYM_NBITS = 4'h3;

    // device register map seen through the serial port
    localparam logic [3:0] CFG_ADDR_ANALOG  = 4'h0;
    localparam logic [3:0] CFG_ADDR_POWER   = 4'h1;
    localparam logic [3:0] CFG_ADDR_RSVD    = 4'h2;
    localparam logic [3:0] CFG_ADDR_DIGITAL = 4'h3;
    localparam logic [3:0] CFG_ADDR_PAT0    = 4'h4;
    localparam logic [3:0] CFG_ADDR_BITTIME = 4'hA;
    localparam logic [3:0] CFG_ADDR_RXSLOT  = 4'hB;
    localparam logic [3:0] CFG_ADDR_LAST    = 4'hC;
    localparam int         ENC_EN_BIT       = 0;
    localparam int         MOD_DEPTH_BIT    = 0;
    localparam logic [7:0] BIT_TIME_MASK    = 8'h1F;
    localparam logic [2:0] SYM_IDX_MAX      = 3'h6;

    // own command port
    localparam int         BUS_AW         = 4;
    localparam int         BUS_DW         = 16;
    localparam logic [3:0] REG_CFG_CMD    = 4'h0;
    localparam logic [3:0] REG_COMM_MODE  = 4'h1;
    localparam logic [3:0] REG_DIRECT_BIT = 4'h2;
    localparam logic [3:0] REG_SYMBOL     = 4'h3;
    localparam logic [3:0] REG_STATUS     = 4'h4;
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_GAP_BIT     = 1;
    localparam int ST_PEND_BIT    = 2;
    localparam int ST_SYNC_BIT    = 3;
    localparam int ST_ENC_BIT     = 4;
    localparam int ST_ERR_CFG_BIT = 8;
    localparam int ST_ERR_SYM_BIT = 9;

    typedef enum logic [1:0] {
        COMM_IDLE, COMM_DIRECT_TX, COMM_RX, COMM_ENC_TX
    } rfhsc_comm_t;

    typedef enum logic [2:0] {
        ST_COMM, ST_CFG_ENTER, ST_CFG_SHIFT, ST_SYM_SHIFT, ST_SYM_WAIT
    } rfhsc_state_t;
endpackage

// File: pkg/rfhsc_ser_if.sv
interface rfhsc_ser_if;
    logic                        start;
    logic [3:0]                  nbits;
    logic [rfhsc_pkg::SER_W-1:0] word;
    logic                        busy;
    logic                        done;
    logic                        sclk;
    logic                        sdat;

    modport ctrl (output start, nbits, word, input busy, done, sclk, sdat);
    modport eng  (input start, nbits, word, output busy, done, sclk, sdat);
endinterface

// File: hw/rfhsc_sync.sv
module rfhsc_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // two flops per bit, first one read only by the second
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule // rfhsc_sync

// File: hw/rfhsc_shifter.sv
module rfhsc_shifter #(
    parameter int CK_HALF = rfhsc_pkg::CK_HALF_CYC
) (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    rfhsc_ser_if.eng  ser
);
    import rfhsc_pkg::*;

    localparam int PW = (CK_HALF > 1) ? $clog2(CK_HALF) : 1;
    localparam logic [PW-1:0] PH_END = PW'(CK_HALF - 1);

    // clock phase must cover pulse width and data setup
    if (CK_HALF < 1 || CK_HALF < SU_CYC) begin : g_chk
        $error("rfhsc_shifter: CK_HALF too small");
    end

    logic             active_reg;
    logic             sclk_reg;
    logic             sdat_reg;
    logic             done_reg;
    logic [SER_W-1:0] sh_reg;
    logic [3:0]       left_reg;
    logic [PW-1:0]    ph_reg;

    // msb-first shift, data moves at load, at each falling clock and on return to idle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            active_reg <= 1'b0;
            sclk_reg   <= 1'b0;
            sdat_reg   <= 1'b1;
            done_reg   <= 1'b0;
            sh_reg     <= '0;
            left_reg   <= '0;
            ph_reg     <= '0;
        end else begin
            done_reg <= 1'b0;
            if (!active_reg) begin
                sclk_reg <= 1'b0;
                sdat_reg <= 1'b1;
                if (ser.start) begin
                    active_reg <= 1'b1;
                    sh_reg     <= ser.word;
                    left_reg   <= ser.nbits;
                    ph_reg     <= '0;
                    sdat_reg   <= ser.word[SER_W-1];
                end
            end else if (ph_reg != PH_END) begin
                ph_reg <= ph_reg + 1'b1;
            end else begin
                ph_reg <= '0;
                if (left_reg == 4'h0) begin
                    active_reg <= 1'b0;
                    done_reg   <= 1'b1;
                end else if (!sclk_reg) begin
                    sclk_reg <= 1'b1;
                end else begin
                    sclk_reg <= 1'b0;
                    left_reg <= left_reg - 1'b1;
                    sh_reg   <= {sh_reg[SER_W-2:0], 1'b0};
                    sdat_reg <= sh_reg[SER_W-2];
                end
            end
        end
    end

    assign ser.busy = active_reg;
    assign ser.done = done_reg;
    assign ser.sclk = sclk_reg;
    assign ser.sdat = sdat_reg;

    a_data_stable: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sclk_reg |-> $stable(sdat_reg))
        else $error("data moved while serial clock high");

    a_msb_first: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (ser.start && !active_reg) |=> (sdat_reg == $past(ser.word[SER_W-1])))
        else $error("first bit is not the msb");
endmodule // rfhsc_shifter

// File: hw/rfhsc_top.sv
module rfhsc_top (
    input  wire logic                         ref_clk,
    input  wire logic                         sys_rst,
    input  wire logic [rfhsc_pkg::BUS_AW-1:0] bus_addr,
    input  wire logic [rfhsc_pkg::BUS_DW-1:0] bus_wdata,
    input  wire logic                         bus_wr,
    input  wire logic                         bus_rd,
    output logic      [rfhsc_pkg::BUS_DW-1:0] bus_rdata,
    output logic                              pin_mode_select,
    output logic                              pin_direction_select,
    output logic                              pin_data_in,
    output logic                              pin_serial_clock_in,
    input  wire logic                         pin_symbol_sync_out
);
    import rfhsc_pkg::*;

    localparam int GW = $clog2(GAP_CYC + 1);
    localparam int SW = $clog2(SU_CYC + 1);

    rfhsc_ser_if ser ();

    rfhsc_state_t         state_reg;
    rfhsc_comm_t          comm_reg;
    logic                 direct_bit_reg;
    logic                 enc_en_reg;
    logic                 pend_reg;
    logic [2:0]           pend_idx_reg;
    logic                 err_cfg_reg;
    logic                 err_sym_reg;
    logic [SER_W-1:0]     last_cfg_reg;
    logic [GW-1:0]        gap_reg;
    logic [SW-1:0]        su_reg;
    logic                 start_reg;
    logic [3:0]           nbits_reg;
    logic [SER_W-1:0]     word_reg;
    logic                 sync_s;
    logic                 sync_prev_reg;
    logic                 sync_rise;
    logic [BUS_DW-1:0]    rdata_reg;
    logic                 mode_reg;
    logic                 dir_reg;
    logic                 din_reg;
    logic                 sclk_reg;
    logic                 mode_next;
    logic                 dir_next;
    logic                 din_next;
    logic                 sclk_next;
    logic [3:0]           cfg_addr;
    logic [7:0]           cfg_data;
    logic                 cfg_wr;
    logic                 cfg_ok;
    logic                 cfg_take;
    logic                 sym_wr;
    logic                 sym_ok;
    logic                 sym_start;
    logic                 sym_queue;
    logic                 pend_use;
    logic [BUS_DW-1:0]    status;

    rfhsc_sync #(.W(1)) u_sync (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .async_in (pin_symbol_sync_out),
        .sync_out (sync_s)
    );

    rfhsc_shifter #(.CK_HALF(CK_HALF_CYC)) u_shift (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .ser     (ser)
    );

    assign ser.start = start_reg;
    assign ser.nbits = nbits_reg;
    assign ser.word  = word_reg;

    // command decode
    assign cfg_addr  = bus_wdata[11:8];
    assign cfg_wr    = bus_wr && (bus_addr == REG_CFG_CMD);
    assign cfg_ok    = (cfg_addr != CFG_ADDR_RSVD) && (cfg_addr <= CFG_ADDR_LAST);
    assign cfg_take  = cfg_wr && cfg_ok && (state_reg == ST_COMM) && (gap_reg == '0);
    assign sym_wr    = bus_wr && (bus_addr == REG_SYMBOL);
    assign sym_ok    = (bus_wdata[2:0] <= SYM_IDX_MAX) && enc_en_reg
                       && (comm_reg == COMM_ENC_TX);
    assign sync_rise = sync_s && !sync_prev_reg;
    assign pend_use  = (state_reg == ST_SYM_WAIT) && sync_rise && pend_reg
                       && (comm_reg == COMM_ENC_TX);
    assign sym_start = sym_wr && sym_ok && (state_reg == ST_COMM);
    assign sym_queue = sym_wr && sym_ok && (state_reg != ST_COMM)
                       && (state_reg != ST_CFG_ENTER) && (state_reg != ST_CFG_SHIFT)
                       && (!pend_reg || pend_use);

    // bit time field only five bits wide, upper bits forced to zero
    always_comb begin
        cfg_data = bus_wdata[7:0];
        if (cfg_addr == CFG_ADDR_BITTIME) begin
            cfg_data = bus_wdata[7:0] & BIT_TIME_MASK;
        end
    end

    // sequencer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= ST_COMM;
            su_reg    <= '0;
        end else begin
            unique case (state_reg)
                ST_COMM: begin
                    su_reg <= '0;
                    if (cfg_take) begin
                        state_reg <= ST_CFG_ENTER;
                    end else if (sym_start) begin
                        state_reg <= ST_SYM_SHIFT;
                    end
                end
                ST_CFG_ENTER: begin
                    su_reg <= su_reg + 1'b1;
                    if (su_reg == SW'(SU_CYC)) begin
                        state_reg <= ST_CFG_SHIFT;
                    end
                end
                ST_CFG_SHIFT: begin
                    if (ser.done) begin
                        state_reg <= ST_COMM;
                    end
                end
                ST_SYM_SHIFT: begin
                    if (ser.done) begin
                        state_reg <= ST_SYM_WAIT;
                    end
                end
                ST_SYM_WAIT: begin
                    if (comm_reg != COMM_ENC_TX) begin
                        state_reg <= ST_COMM;
                    end else if (sync_rise) begin
                        state_reg <= pend_reg ? ST_SYM_SHIFT : ST_COMM;
                    end
                end
            endcase
        end
    end

    // shifter launch: twelve bits for a write, three for a symbol
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            start_reg <= 1'b0;
            nbits_reg <= '0;
            word_reg  <= '0;
        end else begin
            start_reg <= 1'b0;
            if (state_reg == ST_CFG_ENTER && su_reg == SW'(SU_CYC)) begin
                start_reg <= 1'b1;
                nbits_reg <= CFG_NBITS;
                word_reg  <= last_cfg_reg;
            end else if (sym_start) begin
                start_reg <= 1'b1;
                nbits_reg <= SYM_NBITS;
                word_reg  <= {bus_wdata[2:0], {(SER_W - SYM_BITS){1'b0}}};
            end else if (pend_use) begin
                start_reg <= 1'b1;
                nbits_reg <= SYM_NBITS;
                word_reg  <= {pend_idx_reg, {(SER_W - SYM_BITS){1'b0}}};
            end
        end
    end

    // accepted write word and encoder enable tracking
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            last_cfg_reg <= '0;
            enc_en_reg   <= 1'b0;
        end else if (cfg_take) begin
            last_cfg_reg <= {cfg_addr, cfg_data};
            if (cfg_addr == CFG_ADDR_DIGITAL) begin
                enc_en_reg <= cfg_data[ENC_EN_BIT];
            end
        end
    end

    // gap between writes counts from the end of each write
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gap_reg <= '0;
        end else if (state_reg == ST_CFG_SHIFT && ser.done) begin
            gap_reg <= GW'(GAP_CYC);
        end else if (gap_reg != '0) begin
            gap_reg <= gap_reg - 1'b1;
        end
    end

    // software mode selection and direct data level
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            comm_reg       <= COMM_IDLE;
            direct_bit_reg <= 1'b1;
        end else if (bus_wr) begin
            if (bus_addr == REG_COMM_MODE) begin
                comm_reg <= rfhsc_comm_t'(bus_wdata[1:0]);
            end
            if (bus_addr == REG_DIRECT_BIT) begin
                direct_bit_reg <= bus_wdata[0];
            end
        end
    end

    // one waiting symbol; a queue in the taking cycle wins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pend_reg     <= 1'b0;
            pend_idx_reg <= '0;
        end else if (sym_queue) begin
            pend_reg     <= 1'b1;
            pend_idx_reg <= bus_wdata[2:0];
        end else if (pend_use || state_reg == ST_COMM) begin
            pend_reg <= 1'b0;
        end
    end

    // sticky errors, set wins over clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            err_cfg_reg <= 1'b0;
            err_sym_reg <= 1'b0;
        end else begin
            if (cfg_wr && !cfg_take) begin
                err_cfg_reg <= 1'b1;
            end else if (bus_wr && bus_addr == REG_STATUS && bus_wdata[ST_ERR_CFG_BIT]) begin
                err_cfg_reg <= 1'b0;
            end
            if (sym_wr && !sym_start && !sym_queue) begin
                err_sym_reg <= 1'b1;
            end else if (bus_wr && bus_addr == REG_STATUS && bus_wdata[ST_ERR_SYM_BIT]) begin
                err_sym_reg <= 1'b0;
            end
        end
    end

    // sync edge history
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync_prev_reg <= 1'b0;
        end else begin
            sync_prev_reg <= sync_s;
        end
    end

    // status word
    always_comb begin
        status                 = '0;
        status[ST_BUSY_BIT]    = (state_reg != ST_COMM);
        status[ST_GAP_BIT]     = (gap_reg != '0);
        status[ST_PEND_BIT]    = pend_reg;
        status[ST_SYNC_BIT]    = sync_s;
        status[ST_ENC_BIT]     = enc_en_reg;
        status[ST_ERR_CFG_BIT] = err_cfg_reg;
        status[ST_ERR_SYM_BIT] = err_sym_reg;
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !bus_rd) begin
            rdata_reg <= '0;
        end else begin
            unique case (bus_addr)
                REG_CFG_CMD:    rdata_reg <= BUS_DW'(last_cfg_reg);
                REG_COMM_MODE:  rdata_reg <= BUS_DW'(comm_reg);
                REG_DIRECT_BIT: rdata_reg <= BUS_DW'(direct_bit_reg);
                REG_SYMBOL:     rdata_reg <= BUS_DW'(pend_idx_reg);
                REG_STATUS:     rdata_reg <= status;
                default:        rdata_reg <= '0;
            endcase
        end
    end

    // pin levels from the state
    always_comb begin
        // mode drops a cycle after data is forced high, so the two do not move together on entry
        mode_next = !((state_reg == ST_CFG_ENTER && su_reg != '0)
                      || state_reg == ST_CFG_SHIFT);
        dir_next  = mode_next && (state_reg == ST_COMM) && (comm_reg == COMM_RX);
        sclk_next = 1'b0;
        din_next  = 1'b1;
        if (state_reg == ST_CFG_SHIFT || state_reg == ST_SYM_SHIFT) begin
            sclk_next = ser.sclk;
            din_next  = ser.sdat;
        end else if (state_reg == ST_COMM && comm_reg == COMM_DIRECT_TX) begin
            din_next  = direct_bit_reg;
        end
    end

    // pin flops
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_reg <= 1'b1;
            dir_reg  <= 1'b0;
            din_reg  <= 1'b1;
            sclk_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            dir_reg  <= dir_next;
            din_reg  <= din_next;
            sclk_reg <= sclk_next;
        end
    end

    assign bus_rdata            = rdata_reg;
    assign pin_mode_select      = mode_reg;
    assign pin_direction_select = dir_reg;
    assign pin_data_in          = din_reg;
    assign pin_serial_clock_in  = sclk_reg;

    // helper counters for the checks
    logic [3:0]    rise_cnt;
    logic [GW-1:0] high_cnt;
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rise_cnt <= '0;
            high_cnt <= GW'(GAP_CYC);
        end else begin
            if (mode_reg) begin
                rise_cnt <= '0;
            end else if (sclk_next && !sclk_reg) begin
                rise_cnt <= rise_cnt + 1'b1;
            end
            if (!mode_reg) begin
                high_cnt <= '0;
            end else if (high_cnt != GW'(GAP_CYC)) begin
                high_cnt <= high_cnt + 1'b1;
            end
        end
    end

    sequence s_cfg_req;
        cfg_take;
    endsequence
    sequence s_cfg_enter;
        !pin_mode_select && pin_data_in && !pin_serial_clock_in;
    endsequence

    a_cfg_entry: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_cfg_req |-> ##2 (pin_data_in && pin_mode_select) ##1 s_cfg_enter)
        else $error("configuration entry without data high");
    a_no_reserved: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !(!pin_mode_select && pin_direction_select))
        else $error("reserved pin combination driven");
    a_twelve_pulses: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(pin_mode_select) |-> (rise_cnt == 4'(CFG_BITS)))
        else $error("write not twelve clock pulses");
    a_write_gap: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $fell(pin_mode_select) |-> ($past(high_cnt) == GW'(GAP_CYC)))
        else $error("mode high gap too short");
    a_direct_tx: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_reg == ST_COMM && comm_reg == COMM_DIRECT_TX) |=>
        (!pin_serial_clock_in && pin_mode_select && !pin_direction_select
         && pin_data_in == $past(direct_bit_reg)))
        else $error("direct transmit pins wrong");
    a_rx_select: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_reg == ST_COMM && comm_reg == COMM_RX) |=> pin_direction_select)
        else $error("reception not selected");
    a_idle_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (state_reg == ST_COMM && comm_reg != COMM_DIRECT_TX) |=> pin_data_in)
        else $error("data low while idle");
    a_rsvd_refused: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (cfg_wr && cfg_addr == CFG_ADDR_RSVD) |=> (err_cfg_reg && state_reg != ST_CFG_ENTER))
        else $error("reserved address not refused");
    a_sym_next: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pend_use |=> (state_reg == ST_SYM_SHIFT && start_reg))
        else $error("queued symbol not sent after sync");
endmodule // rfhsc_top

// File: bench/rfhsc_dev_model.sv
module rfhsc_dev_model (
    input  wire logic mode,
    input  wire logic dir,
    input  wire logic din,
    input  wire logic sck,
    output logic      sync
);
    timeunit 1ns;
    timeprecision 100ps;
    import rfhsc_pkg::*;
    logic [7:0]  regs [0:12];
    logic [11:0] sh;
    logic [2:0]  sym;
    logic [5:0]  sym_log;
    logic        mod_on;
    logic [6:0]  depth;
    logic        buffered_clock_out = 1'b0;
    localparam realtime BUFFERED_CLOCK_OUT_HALF_NS = 36.87;
    int          n;
    int          bad;
    event        go;
    initial begin
        sync = 1'b0;
        n = 0;
        bad = 0;
        sym = 3'h0;
        sym_log = 6'h00;
        foreach (regs[i]) regs[i] = 8'h00;
    end
    // shift on serial clock rise, symbol after three bits
    always @(posedge sck) begin
        sh = {sh[10:0], din};
        n = n + 1;
        if (mode && !dir && n == 3) begin
            sym = sh[2:0];
            sym_log = {sym_log[2:0], sh[2:0]};
            n = 0;
            -> go;
        end
    end
    // symbol boundary pulse
    always @(go) begin
        #2000 sync = 1'b1;
        #400 sync = 1'b0;
    end
    // commit only whole writes
    always @(posedge mode) begin
        if (n == 12 && sh[11:8] <= 4'hC) regs[sh[11:8]] = sh[7:0];
        n = 0;
    end
    // data must stay high on config entry
    always @(negedge mode) begin
        n = 0;
        if (din !== 1'b1) bad++;
    end
    always @(mode or dir) if (mode === 1'b0 && dir === 1'b1) bad++;
    // carrier modulated only by low data in transmit, never in configuration
    assign mod_on = (mode === 1'b1) && (dir === 1'b0) && (din === 1'b0);
    // modulation depth in percent, hex 64 is full, hex 0A is ten
    assign depth = regs[0][MOD_DEPTH_BIT] ? 7'h64 : 7'h0A;
    // full-rate buffered system clock
    always #(BUFFERED_CLOCK_OUT_HALF_NS) buffered_clock_out = ~buffered_clock_out;
endmodule // rfhsc_dev_model

// File: bench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import rfhsc_pkg::*;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic [3:0]  bus_addr = 4'h0;
    logic [15:0] bus_wdata = 16'h0000;
    logic [15:0] bus_rdata;
    logic [15:0] rd_val;
    logic        mode, dir, din, sck, sync;
    int          error_cnt = 0;
    int          comparisons = 0;
    always #50 ref_clk = ~ref_clk;
    rfhsc_top u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .pin_mode_select(mode), .pin_direction_select(dir), .pin_data_in(din),
        .pin_serial_clock_in(sck), .pin_symbol_sync_out(sync));
    rfhsc_dev_model u_dev (.mode(mode), .dir(dir), .din(din), .sck(sck), .sync(sync));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1 rd_val = bus_rdata;
    endtask
    // poll until neither busy nor gap
    task automatic idle_wait;
        int i;
        for (i = 0; i < 400; i++) begin
            rd(REG_STATUS);
            if (rd_val[1:0] === 2'b00) break;
        end
        if (i == 400) begin
            error_cnt++;
            wrap_up();
        end
    endtask
    task automatic pins(input logic [15:0] exp);
        repeat (4) @(posedge ref_clk);
        #1 chk({12'h000, mode, dir, din, sck}, exp);
    endtask
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        #1 chk({12'h000, mode, dir, din, sck}, 16'h000A);
        wr(REG_CFG_CMD, 16'h0301);
        wr(REG_CFG_CMD, 16'h0C55);
        idle_wait();
        chk({8'h00, u_dev.regs[3]}, 16'h0001);
        chk({8'h00, u_dev.regs[12]}, 16'h0000);
        rd(REG_STATUS);
        chk(rd_val & 16'h0310, 16'h0110);
        wr(REG_STATUS, 16'h0100);
        wr(REG_CFG_CMD, 16'h0277);
        rd(REG_STATUS);
        chk(rd_val & 16'h0100, 16'h0100);
        wr(REG_STATUS, 16'h0100);
        wr(REG_CFG_CMD, 16'h0AFF);
        idle_wait();
        chk({8'h00, u_dev.regs[10]}, 16'h001F);
        wr(REG_CFG_CMD, 16'h0C81);
        idle_wait();
        chk({8'h00, u_dev.regs[12]}, 16'h0081);
        chk({8'h00, u_dev.regs[2]}, 16'h0000);
        // direct transmit follows the data bit
        wr(REG_COMM_MODE, 16'h0001);
        wr(REG_DIRECT_BIT, 16'h0000);
        pins(16'h0008);
        chk({15'h0000, u_dev.mod_on}, 16'h0001);
        // write from direct transmit with data low
        wr(REG_CFG_CMD, 16'h0001);
        idle_wait();
        chk({9'h000, u_dev.depth}, 16'h0064);
        wr(REG_DIRECT_BIT, 16'h0001);
        wr(REG_COMM_MODE, 16'h0002);
        pins(16'h000E);
        // encoded transmit of two symbols, the second queued, bad index refused
        wr(REG_COMM_MODE, 16'h0003);
        wr(REG_SYMBOL, 16'h0005);
        wr(REG_SYMBOL, 16'h0007);
        wr(REG_SYMBOL, 16'h0003);
        rd(REG_SYMBOL);
        chk(rd_val, 16'h0003);
        idle_wait();
        chk({10'h000, u_dev.sym_log}, 16'h002B);
        rd(REG_STATUS);
        chk(rd_val & 16'h0200, 16'h0200);
        chk(u_dev.bad[15:0], 16'h0000);
        wrap_up();
    end
endmodule // tb
